// File: hdl/event_flags_pkg.sv
// Package: addresses, bit positions, widths and reset values of the link event flags
`default_nettype none
package event_flags_pkg;
  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_EVT_SET = 8'h80;
  localparam logic [7:0] ADDR_EVT_CLR = 8'h84;
  localparam logic [7:0] ADDR_MSK_SET = 8'h88;
  localparam logic [7:0] ADDR_MSK_CLR = 8'h8C;
  localparam logic [7:0] ADDR_LINK_SCRATCH = 8'h90;
  // ==========================================================================
  // Event bit positions
  localparam int B_MISMATCH = 23;
  localparam int B_MISSED = 22;
  localparam int B_SIXTY_FOUR = 21;
  localparam int B_NEW_CYCLE = 20;
  localparam int B_PHY_REQ = 19;
  localparam int B_ACC_FAIL = 18;
  localparam int B_BUS_INIT = 17;
  localparam int B_IDENT_PRI = 16;
  localparam int B_IDENT_STK = 15;
  localparam int B_ATOMIC = 9;
  localparam int B_BUF_WRITE = 8;
  // ==========================================================================
  // Field masks and reset values
  localparam logic [31:0] IMPL_MASK = 32'h00FF8300;
  localparam logic [31:0] RSVD_MASK = 32'h00007C00;
  localparam logic [31:0] FLAGS_RESET = 32'h00000000;
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  localparam logic [31:0] SCRATCH_RESET = 32'h00000000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  // ==========================================================================
  // Cycle timer fields
  localparam int SEC_W = 7;
  localparam int CNT_W = 13;
  localparam int SEC_WATCH_BIT = 6;
endpackage
`default_nettype wire

// File: hdl/link_interrupt_event_flags.sv
// Module: event flag register of the serial-bus link, bits 23 down to 8, with APB access
// ============================================================================
//
// Design decisions made here: the APB slave port and the register offsets.
`default_nettype none
module link_interrupt_event_flags (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Local cycle timer
  input wire logic [6:0] timer_seconds_field,
  input wire logic [12:0] timer_cycles_field,
  // Received cycle start and bus activity
  input wire logic rx_cycle_start,
  input wire logic [6:0] rx_seconds,
  input wire logic [12:0] rx_cycles,
  input wire logic cycle_start_seen,
  input wire logic subaction_gap,
  input wire logic arb_reset_gap,
  input wire logic other_packet,
  // Physical layer and transaction status
  input wire logic phy_status_irq,
  input wire logic phy_clk_present,
  input wire logic phy_bus_reset,
  input wire logic self_id_done,
  input wire logic lock_ack_missing,
  input wire logic posted_write_fault,
  // Current flags, unmasked
  output logic [31:0] event_flags
);

  // ==========================================================================
  // Helpers
  // Rising edge of a source level against its previous sample
  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  // Register address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  typedef enum logic [1:0] {CYC_IDLE, CYC_WAIT, CYC_GAP, CYC_DONE} cyc_state_e;

  logic [31:0] flags_q, flags_d;
  logic [31:0] mask_q, mask_d;
  logic [31:0] scratch_q;
  logic [31:0] src_q;
  logic [31:0] prdata_q;
  logic sec_bit_q, cnt_lsb_q;
  cyc_state_e cyc_q, cyc_d;
  logic lost_now;

  // ==========================================================================
  // APB decode
  // Single access cycle; the clock enable stalls the answer too
  wire setup = psel & ~penable;
  wire acc_done = psel & penable & ce;
  wire wr_done = acc_done & pwrite;
  wire a_evt_set = hit(paddr, event_flags_pkg::ADDR_EVT_SET);
  wire a_evt_clr = hit(paddr, event_flags_pkg::ADDR_EVT_CLR);
  wire a_msk_set = hit(paddr, event_flags_pkg::ADDR_MSK_SET);
  wire a_msk_clr = hit(paddr, event_flags_pkg::ADDR_MSK_CLR);
  wire a_scratch = hit(paddr, event_flags_pkg::ADDR_LINK_SCRATCH);
  wire mapped = a_evt_set | a_evt_clr | a_msk_set | a_msk_clr | a_scratch;
  // Link-side register needs the physical layer clock to complete
  wire acc_fail = acc_done & a_scratch & ~phy_clk_present;
  wire wdata_ok = ~|(pwdata & ~event_flags_pkg::IMPL_MASK);
  wire [31:0] wbits = pwdata & event_flags_pkg::IMPL_MASK;
  wire [31:0] sw_set = (wr_done & a_evt_set) ? wbits : event_flags_pkg::ZERO_WORD;
  wire [31:0] sw_clr = (wr_done & a_evt_clr) ? wbits : event_flags_pkg::ZERO_WORD;
  wire unused_ok = wdata_ok;

  assign pready = ce;
  assign pslverr = psel & penable & (~mapped | (a_scratch & ~phy_clk_present));
  assign prdata = prdata_q;
  assign event_flags = flags_q;

  // ==========================================================================
  // Cycle timer watch
  wire sec_bit = timer_seconds_field[event_flags_pkg::SEC_WATCH_BIT];
  wire new_cycle = timer_cycles_field[0] ^ cnt_lsb_q;
  wire sec_change = sec_bit ^ sec_bit_q;
  // Compare whole fields; a received start agreeing with the timer is silent
  wire mismatch = rx_cycle_start & ((rx_seconds != timer_seconds_field) |
                                    (rx_cycles != timer_cycles_field));

  // ==========================================================================
  // Lost cycle tracker
  // A flagged prediction parks in CYC_DONE so the same cycle is not flagged twice
  always_comb begin
    cyc_d = cyc_q;
    lost_now = 1'b0;
    case (cyc_q)
      CYC_IDLE, CYC_DONE: begin
        if (new_cycle) begin
          cyc_d = CYC_WAIT;
        end
      end
      CYC_WAIT: begin
        if (cycle_start_seen) begin
          cyc_d = CYC_DONE;
        end else if (new_cycle) begin
          lost_now = 1'b1;
        end else if (arb_reset_gap) begin
          lost_now = 1'b1;
          cyc_d = CYC_DONE;
        end else if (subaction_gap) begin
          cyc_d = CYC_GAP;
        end
      end
      CYC_GAP: begin
        if (cycle_start_seen) begin
          cyc_d = CYC_DONE;
        end else if (new_cycle | other_packet | arb_reset_gap) begin
          lost_now = 1'b1;
          cyc_d = new_cycle ? CYC_WAIT : CYC_DONE;
        end
      end
      default: begin
        cyc_d = CYC_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Source conditions, one bit per flag, edge detected against last cycle
  logic [31:0] src;
  always_comb begin
    src = event_flags_pkg::ZERO_WORD;
    src[event_flags_pkg::B_MISMATCH] = mismatch;
    src[event_flags_pkg::B_MISSED] = lost_now;
    src[event_flags_pkg::B_SIXTY_FOUR] = sec_change;
    src[event_flags_pkg::B_NEW_CYCLE] = new_cycle;
    src[event_flags_pkg::B_PHY_REQ] = phy_status_irq;
    src[event_flags_pkg::B_ACC_FAIL] = acc_fail;
    src[event_flags_pkg::B_BUS_INIT] = phy_bus_reset;
    src[event_flags_pkg::B_IDENT_PRI] = self_id_done;
    src[event_flags_pkg::B_IDENT_STK] = self_id_done;
    src[event_flags_pkg::B_ATOMIC] = lock_ack_missing;
    src[event_flags_pkg::B_BUF_WRITE] = posted_write_fault;
  end

  // Per-bit rising edge; pulse sources spaced one idle cycle apart each count
  logic [31:0] hw_set;
  always_comb begin
    hw_set = event_flags_pkg::ZERO_WORD;
    for (int i = 0; i < 32; i++) begin
      hw_set[i] = rise(src[i], src_q[i]);
    end
  end

  wire bus_init_edge = hw_set[event_flags_pkg::B_BUS_INIT];
  wire [31:0] ident_kill = bus_init_edge ?
    (32'h00000001 << event_flags_pkg::B_IDENT_PRI) : event_flags_pkg::ZERO_WORD;

  // ==========================================================================
  // Flag and mask next values
  // Set wins over a software clear; the bus reset edge wins over everything on the primary bit
  assign flags_d = (((flags_q & ~sw_clr) | hw_set | sw_set) & ~ident_kill)
                   & event_flags_pkg::IMPL_MASK;
  assign mask_d = (wr_done & a_msk_set) ? (mask_q | wbits) :
                  (wr_done & a_msk_clr) ? (mask_q & ~wbits) : mask_q;

  // ==========================================================================
  // Read data, captured in the setup cycle
  wire [31:0] rd_mux = (a_evt_set | a_evt_clr) ? (flags_q & mask_q) :
                       (a_msk_set | a_msk_clr) ? mask_q :
                       (a_scratch & phy_clk_present) ? scratch_q :
                       event_flags_pkg::ZERO_WORD;

  // ==========================================================================
  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= event_flags_pkg::FLAGS_RESET;
      mask_q <= event_flags_pkg::MASK_RESET;
      src_q <= event_flags_pkg::ZERO_WORD;
      cyc_q <= CYC_IDLE;
    end else if (ce) begin
      flags_q <= flags_d;
      mask_q <= mask_d;
      src_q <= src;
      cyc_q <= cyc_d;
    end
  end

  // Timer history and link scratch; history is caught after reset by the clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_bit_q <= 1'b0;
      cnt_lsb_q <= 1'b0;
      scratch_q <= event_flags_pkg::SCRATCH_RESET;
    end else if (ce) begin
      sec_bit_q <= sec_bit;
      cnt_lsb_q <= timer_cycles_field[0];
      if (wr_done & a_scratch & phy_clk_present) begin
        scratch_q <= pwdata;
      end
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= event_flags_pkg::ZERO_WORD;
    end else if (ce & setup) begin
      prdata_q <= rd_mux;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic unused_tie;
  assign unused_tie = unused_ok;

  mismatch_sets_a: assert property (ce && mismatch && !(ident_kill[event_flags_pkg::B_MISMATCH])
    && !src_q[event_flags_pkg::B_MISMATCH] |=> flags_q[event_flags_pkg::B_MISMATCH])
    else $error("mismatching cycle start did not set its flag");

  lost_between_a: assert property (ce && cyc_q == CYC_WAIT && new_cycle && !cycle_start_seen
    && !src_q[event_flags_pkg::B_MISSED] |=> flags_q[event_flags_pkg::B_MISSED])
    else $error("lost cycle not flagged");

  predict_gap_a: assert property (ce && cyc_q == CYC_GAP && other_packet && !cycle_start_seen
    |-> lost_now ##1 cyc_q != CYC_GAP)
    else $error("gap prediction missed");

  sixty_four_a: assert property (ce && $changed(sec_bit) && $past(ce)
    && !src_q[event_flags_pkg::B_SIXTY_FOUR] |=> flags_q[event_flags_pkg::B_SIXTY_FOUR])
    else $error("seconds bit change not flagged");

  acc_fail_a: assert property (acc_fail && !src_q[event_flags_pkg::B_ACC_FAIL]
    |=> flags_q[event_flags_pkg::B_ACC_FAIL])
    else $error("access failure not flagged before next access");

  ident_kill_a: assert property (ce && bus_init_edge
    |=> !flags_q[event_flags_pkg::B_IDENT_PRI] && flags_q[event_flags_pkg::B_BUS_INIT])
    else $error("bus reset did not clear primary completion");

  sticky_keep_a: assert property (ce && flags_q[event_flags_pkg::B_IDENT_STK] && !sw_clr[event_flags_pkg::B_IDENT_STK]
    |=> flags_q[event_flags_pkg::B_IDENT_STK])
    else $error("sticky completion flag lost");

  rsvd_zero_a: assert property (flags_q[14:10] == 5'h00 && prdata_q[14:10] == 5'h00
    || $past(a_scratch))
    else $error("reserved bits not zero");

  only_clear_a: assert property (ce && !sw_clr[event_flags_pkg::B_ATOMIC] && flags_q[event_flags_pkg::B_ATOMIC]
    |=> flags_q[event_flags_pkg::B_ATOMIC] [*1])
    else $error("flag cleared without clear write");

  read_and_a: assert property (ce && setup && a_evt_set
    |=> prdata_q == ($past(flags_q) & $past(mask_q)))
    else $error("event read is not flags and mask");

  zero_write_a: assert property (wr_done && a_evt_set && pwdata == event_flags_pkg::ZERO_WORD
    && hw_set == event_flags_pkg::ZERO_WORD && !bus_init_edge |=> $stable(flags_q))
    else $error("zero set write changed flags");

  lost_cov_c: cover property (ce && lost_now);
  bus_reset_cov_c: cover property (ce && bus_init_edge && flags_q[event_flags_pkg::B_IDENT_STK]);
  set_clear_cov_c: cover property (wr_done && a_evt_clr ##[1:20] wr_done && a_evt_set);
  fail_cov_c: cover property (acc_fail);

endmodule
`default_nettype wire

// File: dv/phy_side_model.sv
// Bus-side model: cycle timer, cycle starts, PHY status pulses and bus reset sequence
`default_nettype none
module phy_side_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench commands: ctl as one-cycle pulses, clk_off as a held level
  input wire logic [7:0] ctl,
  input wire logic clk_off,
  // Towards the link
  output logic [6:0] secs,
  output logic [12:0] cycs,
  output logic cs_rx,
  output logic [6:0] cs_secs,
  output logic [12:0] cs_cycs,
  output logic cs_seen,
  output logic [2:0] src,
  output logic bus_rst,
  output logic id_done,
  output logic clk_ok
);
  logic [3:0] rst_cnt_q;
  // ==========================================================================
  // Timer and packets; cycle start fields invert every cycle outside a start, so stale values match the timer only every other cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secs <= 7'h00;
      cycs <= 13'h0000;
      cs_rx <= 1'b0;
      cs_seen <= 1'b0;
      cs_secs <= 7'h00;
      cs_cycs <= 13'h0000;
      src <= 3'h0;
      rst_cnt_q <= 4'h0;
    end else begin
      cycs <= cycs + {12'h000, ctl[0]};
      secs <= secs + {6'h00, ctl[1]};
      cs_rx <= ctl[2] | ctl[3];
      cs_seen <= ctl[2] | ctl[3];
      cs_secs <= ctl[3] ? ~secs : (ctl[2] ? secs : ~cs_secs);
      cs_cycs <= (ctl[2] | ctl[3]) ? cycs : ~cs_cycs;
      src <= ctl[7:5];
      rst_cnt_q <= ctl[4] ? 4'h8 : rst_cnt_q - {3'h0, rst_cnt_q != 4'h0};
    end
  end
  // ==========================================================================
  // Bus reset stays high five cycles; the self-ID stream ends a little after it
  assign bus_rst = rst_cnt_q > 4'h3;
  assign id_done = rst_cnt_q == 4'h1;
  assign clk_ok = !clk_off;
endmodule
`default_nettype wire

// File: dv/link_interrupt_event_flags_tb.sv
// Self-checking bench for the link event flag register
`default_nettype none
module link_interrupt_event_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, clk_off, pready, pslverr, err;
  logic [7:0] paddr, ctl;
  logic [31:0] pwdata, prdata, event_flags, rd;
  logic [6:0] secs, cs_secs;
  logic [12:0] cycs, cs_cycs;
  logic [2:0] src;
  logic cs_rx, cs_seen, bus_rst, id_done, clk_ok;
  logic ce, sa_gap, arb_gap, oth_pkt;
  int failures = 0;
  int num_checks = 0;
  // ==========================================================================
  // Design and bus-side partner
  link_interrupt_event_flags u_link_interrupt_event_flags (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_seconds_field(secs), .timer_cycles_field(cycs), .rx_cycle_start(cs_rx),
    .rx_seconds(cs_secs), .rx_cycles(cs_cycs), .cycle_start_seen(cs_seen), .subaction_gap(sa_gap),
    .arb_reset_gap(arb_gap), .other_packet(oth_pkt), .phy_status_irq(src[0]), .phy_clk_present(clk_ok),
    .phy_bus_reset(bus_rst), .self_id_done(id_done), .lock_ack_missing(src[1]),
    .posted_write_fault(src[2]), .event_flags(event_flags));
  phy_side_model u_phy_side_model (
    .pclk(pclk), .presetn(presetn), .ctl(ctl), .clk_off(clk_off), .secs(secs), .cycs(cycs),
    .cs_rx(cs_rx), .cs_secs(cs_secs), .cs_cycs(cs_cycs), .cs_seen(cs_seen), .src(src),
    .bus_rst(bus_rst), .id_done(id_done), .clk_ok(clk_ok));
  // ==========================================================================
  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // APB transfer; waits on pready, one idle cycle after so strobes never toggle twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Bench command to the partner, then time for the flag to land
  task automatic cmd(input logic [7:0] c);
    ctl <= c;
    @(posedge pclk);
    ctl <= 8'h00;
    idle(3);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_soft();
    apb(1'b0, event_flags_pkg::ADDR_MSK_SET, 32'h0);
    chk("mask reset", event_flags_pkg::MASK_RESET, rd);
    apb(1'b1, event_flags_pkg::ADDR_MSK_SET, 32'hFFFFFFFF);
    apb(1'b1, event_flags_pkg::ADDR_EVT_SET, 32'hFFFFFFFF);
    chk("flags all set", event_flags_pkg::IMPL_MASK, event_flags);
    apb(1'b1, event_flags_pkg::ADDR_MSK_CLR, 32'h00F00000);
    apb(1'b0, event_flags_pkg::ADDR_EVT_CLR, 32'h0);
    chk("masked read", event_flags_pkg::IMPL_MASK & 32'hFF0FFFFF, rd);
    apb(1'b1, event_flags_pkg::ADDR_EVT_CLR, 32'h0);
    apb(1'b1, event_flags_pkg::ADDR_EVT_SET, 32'h0);
    chk("zero writes", event_flags_pkg::IMPL_MASK, event_flags);
    apb(1'b1, event_flags_pkg::ADDR_EVT_CLR, 32'hFFFFFFFF);
    chk("clear all", 32'h0, event_flags);
    apb(1'b1, event_flags_pkg::ADDR_MSK_SET, 32'hFFFFFFFF);
    $display("test soft done");
  endtask
  task automatic t_src();
    int b[3] = '{event_flags_pkg::B_PHY_REQ, event_flags_pkg::B_ATOMIC, event_flags_pkg::B_BUF_WRITE};
    for (int i = 0; i < 3; i++) begin
      cmd(8'h20 << i);
      chk("source flag", 32'h1 << b[i], event_flags);
      apb(1'b1, event_flags_pkg::ADDR_EVT_CLR, 32'h1 << b[i]);
      chk("source clear", 32'h0, event_flags);
    end
    $display("test sources done");
  endtask
  task automatic t_busrst();
    cmd(8'h10);
    idle(9);
    chk("reset and ident", 32'h00038000, event_flags);
    apb(1'b1, event_flags_pkg::ADDR_EVT_CLR, 32'h00020000);
    cmd(8'h10);
    chk("reset clears primary", 32'h00028000, event_flags);
    idle(6);
    chk("ident again", 32'h00038000, event_flags);
    apb(1'b1, event_flags_pkg::ADDR_EVT_CLR, 32'hFFFFFFFF);
    $display("test bus reset done");
  endtask
  task automatic t_fail();
    clk_off <= 1'b1;
    apb(1'b1, event_flags_pkg::ADDR_LINK_SCRATCH, 32'h5A5A5A5A);
    chk("fail error", 32'h1, {31'h0, err});
    apb(1'b0, event_flags_pkg::ADDR_EVT_SET, 32'h0);
    chk("fail flag", 32'h1 << event_flags_pkg::B_ACC_FAIL, rd);
    clk_off <= 1'b0;
    apb(1'b0, event_flags_pkg::ADDR_LINK_SCRATCH, 32'h0);
    chk("scratch kept", event_flags_pkg::SCRATCH_RESET, rd);
    apb(1'b0, 8'hA0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, event_flags_pkg::ADDR_EVT_CLR, 32'hFFFFFFFF);
    $display("test access fail done");
  endtask
  task automatic t_cycle();
    cmd(8'h01);
    chk("new cycle", 32'h00100000, event_flags);
    cmd(8'h04);
    cmd(8'h01);
    cmd(8'h04);
    chk("cycle kept", 32'h00100000, event_flags);
    cmd(8'h01);
    cmd(8'h01);
    chk("lost cycle", 32'h00500000, event_flags);
    cmd(8'h08);
    chk("timer mismatch", 32'h00D00000, event_flags);
    repeat (63) cmd(8'h02);
    chk("no sec change", 32'h00D00000, event_flags);
    cmd(8'h02);
    chk("sec bit six", 32'h00F00000, event_flags);
    $display("test cycle done");
  endtask
  // Prediction paths: packet after the first gap, and an arbitration reset gap
  task automatic t_predict();
    apb(1'b1, event_flags_pkg::ADDR_EVT_CLR, 32'hFFFFFFFF);
    cmd(8'h01);
    sa_gap <= 1'b1;
    @(posedge pclk);
    sa_gap <= 1'b0;
    oth_pkt <= 1'b1;
    @(posedge pclk);
    oth_pkt <= 1'b0;
    idle(2);
    chk("gap prediction", 32'h00500000, event_flags);
    apb(1'b1, event_flags_pkg::ADDR_EVT_CLR, 32'hFFFFFFFF);
    cmd(8'h01);
    arb_gap <= 1'b1;
    @(posedge pclk);
    arb_gap <= 1'b0;
    idle(2);
    chk("arb prediction", 32'h00500000, event_flags);
    apb(1'b1, event_flags_pkg::ADDR_EVT_CLR, 32'hFFFFFFFF);
    $display("test predict done");
  endtask
  // Clock enable low freezes state: a source pulse then is not taken
  task automatic t_freeze();
    ce <= 1'b0;
    cmd(8'h20);
    chk("frozen ready", 32'h0, {31'h0, pready});
    ce <= 1'b1;
    idle(2);
    chk("frozen flags", 32'h0, event_flags);
    $display("test freeze done");
  endtask
  // ==========================================================================
  // Verdict, main sequence and watchdog
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ctl = 8'h00;
    clk_off = 1'b0;
    ce = 1'b1;
    sa_gap = 1'b0;
    arb_gap = 1'b0;
    oth_pkt = 1'b0;
    idle(20);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("flags reset", event_flags_pkg::FLAGS_RESET, event_flags);
    t_soft();
    t_src();
    t_busrst();
    t_fail();
    t_cycle();
    t_predict();
    t_freeze();
    give_verdict();
  end
  initial begin
    idle(5000);
    failures++;
    give_verdict();
  end
endmodule
`default_nettype wire
